// file: logic/sfe_sequencer.v
// Serial flash command sequencer: write enable, software reset, erase, suspend
`timescale 1ns/100ps
`include "sfe_consts.vh"

// Function
// - Opcode 06h sets the write enable latch
// - Opcode 04h clears the write enable latch
// - Execute only when select rises on boundary
// - Opcodes arrive on one, two or four lanes
// - Latch resets to zero, gates modify commands
// - Reset needs 66h then 99h, no address
// - Select rise after both opcodes resets device
// - Reset aborts running or suspended operation
// - Reset restores volatile locks and configuration
// - Subsector erase: opcode, three address bytes
// - Sector erase: opcode, three address bytes
// - Bulk erase: opcode only, whole array
// - Erase without latch is silently ignored
// - Erase shows busy, clears latch, clears busy
// - Erase timeout clears latch, sets erase error
// - Locked target: no erase, latch kept, bits 1,5
// - Program suspend: bit 2 now, bit 7 later
// - Erase suspend: bit 6 now, bit 7 later
// - Short remainder finishes and clears suspend bit
// - Flag status powers up as 80h
// - Program to suspended sector: ignored, bit 4
module sfe_sequencer #(
	parameter [31:0] SUBSECTOR_ERASE_CYC = `SFE_SSE_CYC,
	parameter [31:0] SECTOR_ERASE_CYC = `SFE_SE_CYC,
	parameter [31:0] BULK_ERASE_CYC = `SFE_BE_CYC,
	parameter [31:0] PROGRAM_CYC = `SFE_PP_CYC,
	parameter [31:0] SUSPEND_LAT_CYC = `SFE_SUSP_LAT_CYC,
	parameter [31:0] ERASE_TIMEOUT_CYC = `SFE_ERASE_TIMEOUT_CYC
) (
	input wire CORE_CLK,
	input wire RESET,
	input wire SPI_CS_N,
	input wire SPI_SCLK,
	input wire [3:0] SPI_DQ_IN,
	input wire [1:0] PROTO_MODE,
	input wire ARRAY_STALL,
	input wire LOCK_WR_STB,
	input wire [6:0] LOCK_SECTOR,
	input wire LOCK_VALUE,
	input wire [7:0] NV_VOL_CFG,
	input wire [7:0] NV_ENH_CFG,
	input wire VOL_CFG_WR_STB,
	input wire ENH_CFG_WR_STB,
	input wire [7:0] CFG_WR_DATA,
	output reg WEL,
	output wire WIP,
	output wire [7:0] FLAG_STATUS,
	output reg [7:0] VOL_CFG,
	output reg [7:0] ENH_VOL_CFG,
	output reg [127:0] LOCK_BITS,
	output reg ERASE_DONE,
	output reg PROGRAM_DONE,
	output reg [1:0] ERASE_KIND,
	output reg [23:0] OP_ADDR,
	output reg OP_ABORT,
	output reg SOFT_RESET
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_BUSY = 4'b0010;
	localparam [3:0] ST_SUSP_WAIT = 4'b0100;
	localparam [3:0] ST_SUSP = 4'b1000;

	reg [5:0] sync_reg;
	reg [5:0] samp_reg;
	reg cs_n_d_reg;
	reg sclk_d_reg;
	reg [3:0] state_reg;
	reg [7:0] fsr_reg;
	reg [31:0] shift_reg;
	reg [7:0] opcode_reg;
	reg [23:0] addr_reg;
	reg [5:0] bit_cnt_reg;
	reg [2:0] bit_mod_reg;
	reg rst_armed_reg;
	reg op_erase_reg;
	reg [31:0] remain_reg;
	reg [31:0] elapsed_reg;
	reg [31:0] lat_reg;
	reg [6:0] susp_sector_reg;

	wire cs_n_s = samp_reg[4];
	wire sclk_s = samp_reg[5];
	wire [3:0] dq_s = samp_reg[3:0];
	wire cs_fall = cs_n_d_reg & ~cs_n_s;
	wire cs_rise = ~cs_n_d_reg & cs_n_s;
	wire sclk_rise = ~sclk_d_reg & sclk_s;
	wire frame_op = bit_cnt_reg == `SFE_OPCODE_BITS;
	wire frame_addr = bit_cnt_reg == `SFE_ADDR_END_BITS;
	wire frame_prog = (bit_cnt_reg == `SFE_PROG_MIN_BITS) && (bit_mod_reg == 3'h0);
	wire [6:0] addr_sector = addr_reg[`SFE_SECTOR_MSB:`SFE_SECTOR_LSB];
	wire sector_locked = LOCK_BITS[addr_sector];
	wire any_locked = |LOCK_BITS;
	wire erase_cmd = (opcode_reg == `SFE_OP_SSE) || (opcode_reg == `SFE_OP_SE);
	wire op_finish = (remain_reg == 32'h0) && !ARRAY_STALL;
	wire op_timeout = op_erase_reg && (elapsed_reg == ERASE_TIMEOUT_CYC);

	reg [2:0] step;
	reg [31:0] shifted;

	// Lane count per protocol
	always @* begin
		step = 3'h1;
		shifted = {shift_reg[30:0], dq_s[0]};
		case (PROTO_MODE)
			`SFE_PROTO_DUAL: begin
				step = 3'h2;
				shifted = {shift_reg[29:0], dq_s[1:0]};
			end
			`SFE_PROTO_QUAD: begin
				step = 3'h4;
				shifted = {shift_reg[27:0], dq_s[3:0]};
			end
			default: begin
				step = 3'h1;
				shifted = {shift_reg[30:0], dq_s[0]};
			end
		endcase
	end

	// Pin inputs pass two flip-flops before any logic
	always @(posedge CORE_CLK) begin
		sync_reg <= {SPI_SCLK, SPI_CS_N, SPI_DQ_IN};
		samp_reg <= sync_reg;
		cs_n_d_reg <= cs_n_s;
		sclk_d_reg <= sclk_s;
	end

	assign WIP = (state_reg != ST_IDLE) && (state_reg != ST_SUSP);
	assign FLAG_STATUS = {~WIP, fsr_reg[6:0]};

	always @(posedge CORE_CLK) begin
		if (RESET || SOFT_RESET) begin
			state_reg <= ST_IDLE;
			fsr_reg <= `SFE_FSR_RESET;
			WEL <= 1'b0;
			VOL_CFG <= NV_VOL_CFG;
			ENH_VOL_CFG <= NV_ENH_CFG;
			LOCK_BITS <= `SFE_LOCK_RESET;
			shift_reg <= 32'h0;
			opcode_reg <= 8'h0;
			addr_reg <= 24'h0;
			bit_cnt_reg <= 6'h0;
			bit_mod_reg <= 3'h0;
			rst_armed_reg <= 1'b0;
			op_erase_reg <= 1'b0;
			remain_reg <= 32'h0;
			elapsed_reg <= 32'h0;
			lat_reg <= 32'h0;
			susp_sector_reg <= 7'h0;
			ERASE_DONE <= 1'b0;
			PROGRAM_DONE <= 1'b0;
			ERASE_KIND <= `SFE_KIND_SUBSECTOR;
			OP_ADDR <= 24'h0;
			OP_ABORT <= SOFT_RESET && (state_reg != ST_IDLE);
			SOFT_RESET <= 1'b0;
		end else begin
			ERASE_DONE <= 1'b0;
			PROGRAM_DONE <= 1'b0;
			OP_ABORT <= 1'b0;
			if (VOL_CFG_WR_STB)
				VOL_CFG <= CFG_WR_DATA;
			if (ENH_CFG_WR_STB)
				ENH_VOL_CFG <= CFG_WR_DATA;
			if (LOCK_WR_STB)
				LOCK_BITS[LOCK_SECTOR] <= LOCK_VALUE;

			// Frame capture
			if (cs_fall) begin
				bit_cnt_reg <= 6'h0;
				bit_mod_reg <= 3'h0;
			end else if (sclk_rise && !cs_n_s) begin
				shift_reg <= shifted;
				bit_mod_reg <= bit_mod_reg + step;
				if (bit_cnt_reg < `SFE_PROG_MIN_BITS)
					bit_cnt_reg <= bit_cnt_reg + {3'h0, step};
				if (bit_cnt_reg + {3'h0, step} == `SFE_OPCODE_BITS)
					opcode_reg <= shifted[7:0];
				if (bit_cnt_reg + {3'h0, step} == `SFE_ADDR_END_BITS)
					addr_reg <= shifted[23:0];
			end

			// Self-timed operation
			case (state_reg)
				ST_BUSY: begin
					if (remain_reg != 32'h0)
						remain_reg <= remain_reg - 32'h1;
					elapsed_reg <= elapsed_reg + 32'h1;
					if (op_timeout) begin
						state_reg <= ST_IDLE;
						WEL <= 1'b0;
						fsr_reg[`SFE_FSR_ERS_ERR] <= 1'b1;
						fsr_reg[`SFE_FSR_ERS_SUSP] <= 1'b0;
					end else if (op_finish) begin
						state_reg <= ST_IDLE;
						ERASE_DONE <= op_erase_reg;
						PROGRAM_DONE <= ~op_erase_reg;
						fsr_reg[`SFE_FSR_ERS_SUSP] <= 1'b0;
						fsr_reg[`SFE_FSR_PGM_SUSP] <= 1'b0;
					end
				end
				ST_SUSP_WAIT: begin
					lat_reg <= lat_reg - 32'h1;
					if (lat_reg <= 32'h1)
						state_reg <= ST_SUSP;
				end
				ST_SUSP: begin
					state_reg <= ST_SUSP;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase

			// Command execution on select rise at a byte boundary
			if (cs_rise) begin
				rst_armed_reg <= 1'b0;
				if (frame_op) begin
					case (opcode_reg)
						`SFE_OP_WREN: begin
							if (state_reg == ST_IDLE || state_reg == ST_SUSP)
								WEL <= 1'b1;
						end
						`SFE_OP_WRDI: begin
							if (state_reg == ST_IDLE || state_reg == ST_SUSP)
								WEL <= 1'b0;
						end
						`SFE_OP_RST_EN: begin
							rst_armed_reg <= 1'b1;
						end
						`SFE_OP_RST_MEM: begin
							if (rst_armed_reg)
								SOFT_RESET <= 1'b1;
						end
						`SFE_OP_BE: begin
							if (state_reg == ST_IDLE && WEL) begin
								if (any_locked) begin
									fsr_reg[`SFE_FSR_ERS_ERR] <= 1'b1;
									fsr_reg[`SFE_FSR_PROT_ERR] <= 1'b1;
								end else begin
									state_reg <= ST_BUSY;
									WEL <= 1'b0;
									op_erase_reg <= 1'b1;
									remain_reg <= BULK_ERASE_CYC;
									elapsed_reg <= 32'h0;
									ERASE_KIND <= `SFE_KIND_BULK;
									OP_ADDR <= 24'h0;
								end
							end
						end
						`SFE_OP_SUSP: begin
							if (state_reg == ST_BUSY && !op_timeout && !op_finish) begin
								if (op_erase_reg)
									fsr_reg[`SFE_FSR_ERS_SUSP] <= 1'b1;
								else
									fsr_reg[`SFE_FSR_PGM_SUSP] <= 1'b1;
								if (remain_reg >= SUSPEND_LAT_CYC) begin
									state_reg <= ST_SUSP_WAIT;
									lat_reg <= SUSPEND_LAT_CYC;
									susp_sector_reg <= OP_ADDR[`SFE_SECTOR_MSB:`SFE_SECTOR_LSB];
								end
							end
						end
						`SFE_OP_RESUME: begin
							if (state_reg == ST_SUSP) begin
								state_reg <= ST_BUSY;
								fsr_reg[`SFE_FSR_ERS_SUSP] <= 1'b0;
								fsr_reg[`SFE_FSR_PGM_SUSP] <= 1'b0;
							end
						end
						default: begin
							rst_armed_reg <= 1'b0;
						end
					endcase
				end else if (frame_addr && erase_cmd) begin
					if (state_reg == ST_IDLE && WEL) begin
						if (sector_locked) begin
							fsr_reg[`SFE_FSR_ERS_ERR] <= 1'b1;
							fsr_reg[`SFE_FSR_PROT_ERR] <= 1'b1;
						end else begin
							state_reg <= ST_BUSY;
							WEL <= 1'b0;
							op_erase_reg <= 1'b1;
							elapsed_reg <= 32'h0;
							if (opcode_reg == `SFE_OP_SSE) begin
								remain_reg <= SUBSECTOR_ERASE_CYC;
								ERASE_KIND <= `SFE_KIND_SUBSECTOR;
								OP_ADDR <= {addr_reg[23:`SFE_SUBSECTOR_LSB], 12'h000};
							end else begin
								remain_reg <= SECTOR_ERASE_CYC;
								ERASE_KIND <= `SFE_KIND_SECTOR;
								OP_ADDR <= {addr_reg[23:`SFE_SECTOR_LSB], 16'h0000};
							end
						end
					end
				end else if (frame_prog && opcode_reg == `SFE_OP_PP) begin
					if (state_reg == ST_SUSP && op_erase_reg) begin
						if (addr_sector == susp_sector_reg)
							fsr_reg[`SFE_FSR_PGM_ERR] <= 1'b1;
					end else if (state_reg == ST_IDLE && WEL) begin
						if (sector_locked) begin
							fsr_reg[`SFE_FSR_PGM_ERR] <= 1'b1;
							fsr_reg[`SFE_FSR_PROT_ERR] <= 1'b1;
						end else begin
							state_reg <= ST_BUSY;
							WEL <= 1'b0;
							op_erase_reg <= 1'b0;
							remain_reg <= PROGRAM_CYC;
							elapsed_reg <= 32'h0;
							OP_ADDR <= addr_reg;
						end
					end
				end
			end
		end
	end

endmodule

// file: logic/sfe_consts.vh
// Constants for the serial flash erase, reset and suspend sequencer
`ifndef SFE_CONSTS_VH
`define SFE_CONSTS_VH

// Opcodes
`define SFE_OP_WREN 8'h06
`define SFE_OP_WRDI 8'h04
`define SFE_OP_RST_EN 8'h66
`define SFE_OP_RST_MEM 8'h99
`define SFE_OP_SSE 8'h20
`define SFE_OP_SE 8'hd8
`define SFE_OP_BE 8'hc7
`define SFE_OP_PP 8'h02
`define SFE_OP_SUSP 8'h75
`define SFE_OP_RESUME 8'h7a

// Frame bit counts
`define SFE_OPCODE_BITS 6'h08
`define SFE_ADDR_END_BITS 6'h20
`define SFE_PROG_MIN_BITS 6'h28

// Lane modes on PROTO_MODE
`define SFE_PROTO_EXT 2'h0
`define SFE_PROTO_DUAL 2'h1
`define SFE_PROTO_QUAD 2'h2

// Flag status register
`define SFE_FSR_RESET 8'h80
`define SFE_FSR_READY 7
`define SFE_FSR_ERS_SUSP 6
`define SFE_FSR_ERS_ERR 5
`define SFE_FSR_PGM_ERR 4
`define SFE_FSR_PGM_SUSP 2
`define SFE_FSR_PROT_ERR 1

// Erase kinds on ERASE_KIND
`define SFE_KIND_SUBSECTOR 2'h0
`define SFE_KIND_SECTOR 2'h1
`define SFE_KIND_BULK 2'h2

// Address fields
`define SFE_SECTOR_MSB 22
`define SFE_SECTOR_LSB 16
`define SFE_SUBSECTOR_LSB 12
`define SFE_LOCK_RESET 128'h0

// Self-timed operation defaults in cycles of CORE_CLK
`define SFE_SSE_CYC 32'h00001388
`define SFE_SE_CYC 32'h00002710
`define SFE_BE_CYC 32'h00004e20
`define SFE_PP_CYC 32'h000003e8
`define SFE_SUSP_LAT_CYC 32'h00000064
`define SFE_ERASE_TIMEOUT_CYC 32'h00030d40

`endif

// file: dv/sfe_props.sv
// Checker for the flash command sequencer
`timescale 1ns/100ps
module sfe_props (
	input wire CORE_CLK,
	input wire RESET,
	input wire SPI_CS_N,
	input wire WEL,
	input wire WIP,
	input wire [7:0] FLAG_STATUS,
	input wire [7:0] VOL_CFG,
	input wire [7:0] NV_VOL_CFG,
	input wire [127:0] LOCK_BITS,
	input wire ERASE_DONE,
	input wire OP_ABORT,
	input wire SOFT_RESET
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	property p_wel; $rose(WEL) |-> SPI_CS_N && $past(SPI_CS_N, 2); endproperty
	a_wel: assert property (p_wel) else $error("latch set inside a frame");
	property p_busy; $rose(WIP) |-> !WEL; endproperty
	a_busy: assert property (p_busy) else $error("latch kept at erase start");
	property p_rdy; $fell(RESET) |-> FLAG_STATUS == 8'h80 && !WEL && !WIP; endproperty
	a_rdy: assert property (p_rdy) else $error("state after reset wrong");
	property p_done; ERASE_DONE |-> $past(WIP) ##1 (!WIP && !ERASE_DONE && !FLAG_STATUS[6]);
	endproperty
	a_done: assert property (p_done) else $error("erase end wrong");
	property p_err; $rose(FLAG_STATUS[5]) |-> (FLAG_STATUS[1] ? WEL : !WIP && !WEL); endproperty
	a_err: assert property (p_err) else $error("erase error flags wrong");
	property p_susp; $rose(FLAG_STATUS[6]) |-> WIP[*3] ##[1:6] FLAG_STATUS[7]; endproperty
	a_susp: assert property (p_susp) else $error("suspend latency wrong");
	property p_pgm; $rose(FLAG_STATUS[4]) |-> $stable(WEL) && FLAG_STATUS[7]; endproperty
	a_pgm: assert property (p_pgm) else $error("program refusal wrong");
	property p_srst; SOFT_RESET |-> SPI_CS_N ##1
		(FLAG_STATUS == 8'h80 && !WEL && LOCK_BITS == 128'h0 && VOL_CFG == NV_VOL_CFG);
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset state wrong");
	property p_abort; OP_ABORT |-> $past(SOFT_RESET) && !WIP; endproperty
	a_abort: assert property (p_abort) else $error("abort without reset");
endmodule
bind sfe_sequencer sfe_props i_props(.CORE_CLK, .RESET, .SPI_CS_N, .WEL, .WIP, .FLAG_STATUS,
	.VOL_CFG, .NV_VOL_CFG, .LOCK_BITS, .ERASE_DONE, .OP_ABORT, .SOFT_RESET);

// file: dv/sfe_host.sv
// Host controller model driving select, serial clock and data lanes
`timescale 1ns/100ps
module sfe_host (
	input wire clk,
	input wire [1:0] mode,
	output reg cs_n,
	output reg sclk,
	output reg [3:0] dq
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dq = 4'h5;
	end
	// Sends n bits of d MSB first; SCLK idles low, lanes toggle when released
	task frame(input [39:0] d, input integer n);
		integer i;
		integer w;
		begin
			@(posedge clk) cs_n <= 1'b0;
			w = (mode == 2'h2) ? 4 : (mode == 2'h1) ? 2 : 1;
			for (i = 0; i < n; i = i + w) begin
				@(posedge clk) dq <= 4'((d << i) >> (40 - w));
				repeat (4) @(posedge clk);
				sclk <= 1'b1;
				repeat (4) @(posedge clk);
				sclk <= 1'b0;
			end
			repeat (4) @(posedge clk);
			cs_n <= 1'b1;
			dq <= ~dq;
			repeat (6) @(posedge clk);
			@(negedge clk);
		end
	endtask
endmodule

// file: dv/test_serial_flash_erase_reset_suspend.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`include "sfe_consts.vh"
module test_serial_flash_erase_reset_suspend;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [1:0] mode = 2'h0;
	reg stall = 1'b0;
	reg lk_stb = 1'b0;
	reg [6:0] lk_sec = 7'h0;
	reg vc_stb = 1'b0;
	reg en_stb = 1'b0;
	reg lk_val = 1'b1;
	reg [7:0] nv_vol = 8'ha5;
	reg [7:0] nv_enh = 8'h3c;
	integer w;
	reg [7:0] vc_data = 8'h0;
	reg aborted = 1'b0;
	integer checks = 0;
	integer failures = 0;
	integer cyc = 0;
	integer m;
	wire cs_n, sclk, wel, wip, edone, pdone, abort;
	wire [3:0] dq;
	wire [7:0] fsr, vcfg, enh;
	wire [127:0] locks;
	wire [1:0] kind;
	wire [23:0] addr;
	sfe_host i_host(.clk(clk), .mode(mode), .cs_n(cs_n), .sclk(sclk), .dq(dq));
	sfe_sequencer #(.SUBSECTOR_ERASE_CYC(32'h14), .SECTOR_ERASE_CYC(32'hc8),
		.BULK_ERASE_CYC(32'h28), .SUSPEND_LAT_CYC(32'h5),
		.ERASE_TIMEOUT_CYC(32'h190)) i_dut(.CORE_CLK(clk), .RESET(rst), .SPI_CS_N(cs_n),
		.SPI_SCLK(sclk), .SPI_DQ_IN(dq), .PROTO_MODE(mode), .ARRAY_STALL(stall),
		.LOCK_WR_STB(lk_stb), .LOCK_SECTOR(lk_sec), .LOCK_VALUE(lk_val), .NV_VOL_CFG(nv_vol),
		.NV_ENH_CFG(nv_enh), .VOL_CFG_WR_STB(vc_stb), .ENH_CFG_WR_STB(en_stb),
		.CFG_WR_DATA(vc_data), .WEL(wel), .WIP(wip), .FLAG_STATUS(fsr), .VOL_CFG(vcfg),
		.ENH_VOL_CFG(enh), .LOCK_BITS(locks), .ERASE_DONE(edone), .PROGRAM_DONE(pdone),
		.ERASE_KIND(kind), .OP_ADDR(addr), .OP_ABORT(abort), .SOFT_RESET());
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (abort)
			aborted <= 1'b1;
		if (cyc == 30000) begin
			failures = failures + 1;
			end_of_test;
		end
	end
	task chk(input [159:0] got, input [159:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cmd(input [7:0] op);
		i_host.frame({op, 32'h0}, 8);
	endtask
	task ers(input [7:0] op, input [23:0] a);
		i_host.frame({op, a, 8'h0}, 32);
	endtask
	task note(input string s);
		$display("test %0s done", s);
	endtask
	task end_of_test;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(negedge clk);
		chk({wel, wip, fsr, vcfg, enh, locks}, {2'b00, 8'h80, 8'ha5, 8'h3c, 128'h0});
		note("reset");
		for (m = 0; m < 3; m = m + 1) begin
			@(posedge clk) mode <= m[1:0];
			cmd(`SFE_OP_WREN);
			chk(wel, 1);
			cmd(`SFE_OP_WRDI);
			chk(wel, 0);
		end
		@(posedge clk) mode <= 2'h0;
		i_host.frame({`SFE_OP_WREN, 32'h0}, 7);
		chk(wel, 0);
		cmd(`SFE_OP_WREN);
		i_host.frame({`SFE_OP_WRDI, 32'h0}, 9);
		chk(wel, 1);
		note("latch");
		cmd(`SFE_OP_WRDI);
		ers(`SFE_OP_SE, 24'h054321);
		chk({wip, fsr}, {1'b0, 8'h80});
		for (m = 0; m < 3; m = m + 1) begin
			cmd(`SFE_OP_WREN);
			if (m == 2)
				cmd(`SFE_OP_BE);
			else
				ers(m ? `SFE_OP_SE : `SFE_OP_SSE, 24'h054321);
			chk({wip, wel, kind, addr}, {2'b10, m[1:0],
				m == 0 ? 24'h054000 : m == 1 ? 24'h050000 : 24'h0});
			w = 0;
			while (edone !== 1'b1 && w < 500) begin
				w = w + 1;
				@(negedge clk);
			end
			chk(edone, 1);
			@(negedge clk);
			chk({wip, fsr}, {1'b0, 8'h80});
		end
		note("erase");
		@(posedge clk) lk_sec <= 7'h05;
		lk_stb <= 1'b1;
		@(posedge clk) lk_stb <= 1'b0;
		cmd(`SFE_OP_WREN);
		ers(`SFE_OP_SE, 24'h05ffff);
		chk({wip, wel, fsr}, {2'b01, 8'ha2});
		cmd(`SFE_OP_BE);
		chk({wip, wel}, 2'b01);
		@(posedge clk) vc_data <= 8'h5a;
		vc_stb <= 1'b1;
		en_stb <= 1'b1;
		@(posedge clk) vc_stb <= 1'b0;
		en_stb <= 1'b0;
		cmd(`SFE_OP_RST_EN);
		cmd(`SFE_OP_WREN);
		cmd(`SFE_OP_RST_MEM);
		chk({wel, vcfg, enh, locks[5]}, {1'b1, 8'h5a, 8'h5a, 1'b1});
		cmd(`SFE_OP_RST_EN);
		cmd(`SFE_OP_RST_MEM);
		chk({wel, vcfg, enh, fsr, locks}, {1'b0, 8'ha5, 8'h3c, 8'h80, 128'h0});
		note("lock and reset");
		cmd(`SFE_OP_WREN);
		ers(`SFE_OP_SE, 24'h030000);
		cmd(`SFE_OP_SUSP);
		repeat (10) @(negedge clk);
		chk({wip, fsr}, {1'b0, 8'hc0});
		cmd(`SFE_OP_WREN);
		i_host.frame({`SFE_OP_PP, 24'h031234, 8'h5a}, 40);
		chk({wel, fsr}, {1'b1, 8'hd0});
		cmd(`SFE_OP_RST_EN);
		cmd(`SFE_OP_RST_MEM);
		chk({aborted, fsr}, {1'b1, 8'h80});
		note("suspend");
		cmd(`SFE_OP_WREN);
		i_host.frame({`SFE_OP_PP, 24'h010000, 8'h5a}, 40);
		cmd(`SFE_OP_SUSP);
		repeat (10) @(negedge clk);
		chk({wip, fsr}, {1'b0, 8'h84});
		cmd(`SFE_OP_RESUME);
		chk({wip, fsr}, {1'b1, 8'h00});
		w = 0;
		while (pdone !== 1'b1 && w < 1100) begin
			w = w + 1;
			@(negedge clk);
		end
		chk(pdone, 1);
		@(negedge clk);
		chk({wip, wel, fsr}, {2'b00, 8'h80});
		note("program suspend");
		@(posedge clk) stall <= 1'b1;
		cmd(`SFE_OP_WREN);
		ers(`SFE_OP_SE, 24'h0);
		repeat (420) @(negedge clk);
		chk({wip, wel, fsr}, {2'b00, 8'ha0});
		note("timeout");
		end_of_test;
	end
endmodule
